// [hw/bfpden_denormalizer.v]
`timescale 1ns/1ps
`include "bfpden_regs.vh"

module bfpden_denormalizer #(
    parameter DATA_W    = `BFPDEN_DATA_W,
    parameter EXP_W     = `BFPDEN_EXP_W,
    parameter MAX_LOG2N = `BFPDEN_MAX_LOG2N,
    parameter OUT_W     = `BFPDEN_OUT_W,
    parameter OUT_LSB   = `BFPDEN_OUT_LSB
) (
    // clock and reset
    input  wire                        clk,
    input  wire                        rstn,
    // configuration
    input  wire [3:0]                  log2Len,
    input  wire                        quadEngine,
    input  wire                        pairMode,
    // sample stream from the transform engine
    input  wire                        inValid,
    input  wire                        inInverse,
    input  wire [DATA_W-1:0]           realIn,
    input  wire [DATA_W-1:0]           imagIn,
    input  wire [EXP_W-1:0]            blockExp,
    // full-scale stream
    output reg                         outValid,
    output reg  [DATA_W+3*((MAX_LOG2N+1)/2)-1:0] fullReal,
    output reg  [DATA_W+3*((MAX_LOG2N+1)/2)-1:0] fullImag,
    // selected slice
    output reg  [OUT_W-1:0]            sliceReal,
    output reg  [OUT_W-1:0]            sliceImag,
    output reg                         sliceSat,
    output reg                         expRangeErr,
    // exponent bookkeeping
    output reg  [EXP_W:0]              totalExp,
    output reg  [EXP_W-1:0]            inverseStageExp,
    output reg                         needDivByN
);

    // =====================================================================
    // widths
    // largest left shift is 3P-R, at most 3*ceil(MAX_LOG2N/2)
    localparam SHIFT_MAX = 3 * ((MAX_LOG2N + 1) / 2);
    localparam FULL_W    = DATA_W + SHIFT_MAX;
    // room for the largest pair-sum shift, so no bit is lost before the overflow test
    localparam PRE_W     = FULL_W + (1 << EXP_W);

    // =====================================================================
    // exponent range from transform length
    wire [3:0] passCnt = (log2Len + 4'h1) >> 1;
    wire       oddOff  = log2Len[0];
    wire signed [7:0] pS = {4'h0, passCnt};
    wire signed [7:0] rS = {7'h00, oddOff};
    // bounds are worked out at integer width, then cut to eight bits on purpose
    wire signed [31:0] loSgl = -`BFPDEN_LO_MUL * pS + rS + `BFPDEN_SGL_LO_ADD;
    wire signed [31:0] loQud = -`BFPDEN_LO_MUL * pS + rS + `BFPDEN_QUD_LO_ADD;
    wire signed [31:0] hiSgl = pS + rS - `BFPDEN_SGL_HI_SUB;
    wire signed [31:0] hiQud = pS + rS - `BFPDEN_QUD_HI_SUB;
    wire signed [7:0]  expLo = quadEngine ? loQud[7:0] : loSgl[7:0];
    wire signed [7:0]  expHi = quadEngine ? hiQud[7:0] : hiSgl[7:0];

    // =====================================================================
    // exponent bookkeeping across an inverse then forward pair
    reg  [EXP_W-1:0] heldInvExp_q;
    reg              heldValid_q;
    wire signed [EXP_W-1:0] expS = blockExp;
    wire signed [EXP_W:0]   combExp = (pairMode && !inInverse && heldValid_q) ?
        ({expS[EXP_W-1], expS} + {heldInvExp_q[EXP_W-1], heldInvExp_q}) :
        {expS[EXP_W-1], expS};
    wire signed [7:0] expW = {{(8-EXP_W){expS[EXP_W-1]}}, expS};
    wire outOfRange = (expW < expLo) || (expW > expHi);

    // =====================================================================
    // placement: sign-extend then shift by -exponent
    // sign extension to the working width, shared by both parts
    function [PRE_W-1:0] signExt;
        input [DATA_W-1:0] s;
        begin
            signExt = {{(PRE_W-DATA_W){s[DATA_W-1]}}, s};
        end
    endfunction

    wire signed [PRE_W-1:0] realExt = signExt(realIn);
    wire signed [PRE_W-1:0] imagExt = signExt(imagIn);
    wire        leftShift = combExp[EXP_W];
    wire [EXP_W:0] shAmt  = leftShift ? (~combExp + 1'b1) : combExp;

    function [PRE_W-1:0] place;
        input [PRE_W-1:0] v;
        input             lft;
        input [EXP_W:0]   n;
        begin
            if (lft) begin
                place = v << n;                               // zeros pad low bits
            end else begin
                place = $signed(v) >>> n;
            end
        end
    endfunction

    wire [PRE_W-1:0] realPl = place(realExt, leftShift, shAmt);
    wire [PRE_W-1:0] imagPl = place(imagExt, leftShift, shAmt);

    // saturated value at full-scale width
    localparam [FULL_W-1:0] FULL_POS = {1'b0, {(FULL_W-1){1'b1}}};
    localparam [FULL_W-1:0] FULL_NEG = {1'b1, {(FULL_W-1){1'b0}}};

    function [FULL_W-1:0] fullSat;
        input [PRE_W-1:0] v;
        input             forceSat;
        input             sgn;
        begin
            if (forceSat || (v[PRE_W-1:FULL_W-1] != {(PRE_W-FULL_W+1){v[PRE_W-1]}})) begin
                fullSat = sgn ? FULL_NEG : FULL_POS;
            end else begin
                fullSat = v[FULL_W-1:0];
            end
        end
    endfunction

    // slice of the full-scale word, saturating on overflow
    function [OUT_W:0] slice;
        input [FULL_W-1:0] v;
        reg   [FULL_W-1:0] q;
        begin
            q = $signed(v) >>> OUT_LSB;
            if (q[FULL_W-1:OUT_W-1] != {(FULL_W-OUT_W+1){v[FULL_W-1]}}) begin
                slice = {1'b1, v[FULL_W-1], {(OUT_W-1){~v[FULL_W-1]}}};
            end else begin
                slice = {1'b0, q[OUT_W-1:0]};
            end
        end
    endfunction

    wire [FULL_W-1:0] realFull_d = fullSat(realPl, outOfRange, realIn[DATA_W-1]);
    wire [FULL_W-1:0] imagFull_d = fullSat(imagPl, outOfRange, imagIn[DATA_W-1]);
    wire [OUT_W:0]    realSl = slice(realFull_d);
    wire [OUT_W:0]    imagSl = slice(imagFull_d);

    // =====================================================================
    // registers
    // the slice is taken only from the complete full-scale word, never from
    // a truncated intermediate, so no exponent information is discarded
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outValid <= 1'b0;
        end else begin
            outValid <= inValid;
        end
    end

    // =====================================================================
    // data words
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fullReal  <= {FULL_W{1'b0}};
            fullImag  <= {FULL_W{1'b0}};
            sliceReal <= {OUT_W{1'b0}};
            sliceImag <= {OUT_W{1'b0}};
        end else if (inValid) begin
            fullReal  <= realFull_d;
            fullImag  <= imagFull_d;
            sliceReal <= realSl[OUT_W-1:0];
            sliceImag <= imagSl[OUT_W-1:0];
        end
    end

    // =====================================================================
    // status flags
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sliceSat    <= 1'b0;
            expRangeErr <= 1'b0;
            needDivByN  <= 1'b0;
        end else if (inValid) begin
            sliceSat    <= realSl[OUT_W] | imagSl[OUT_W] | outOfRange;
            expRangeErr <= outOfRange;
            needDivByN  <= inInverse | (pairMode & heldValid_q);
        end
    end

    // =====================================================================
    // exponent bookkeeping registers
    // the held exponent is dropped once pair mode is left, so a stale
    // inverse exponent never leaks into a later unrelated forward block
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            totalExp        <= {(EXP_W+1){1'b0}};
            inverseStageExp <= {EXP_W{1'b0}};
            heldInvExp_q    <= {EXP_W{1'b0}};
            heldValid_q     <= 1'b0;
        end else begin
            if (inValid) begin
                totalExp <= combExp;
            end
            if (inValid && pairMode && inInverse) begin
                heldInvExp_q    <= blockExp;
                heldValid_q     <= 1'b1;
                inverseStageExp <= blockExp;
            end else if (!pairMode) begin
                heldValid_q     <= 1'b0;
            end
        end
    end

endmodule // bfpden_denormalizer

// [include/bfpden_regs.vh]
`ifndef BFPDEN_REGS_VH
`define BFPDEN_REGS_VH
// =====================================================================
// datapath dimensions
`define BFPDEN_DATA_W      16
`define BFPDEN_EXP_W       6
`define BFPDEN_MAX_LOG2N   14
`define BFPDEN_OUT_W       16
`define BFPDEN_OUT_LSB     0
// =====================================================================
// engine kinds
`define BFPDEN_ENG_SINGLE  1'b0
`define BFPDEN_ENG_QUAD    1'b1
// =====================================================================
// range formula offsets
`define BFPDEN_LO_MUL      3
`define BFPDEN_SGL_LO_ADD  0
`define BFPDEN_SGL_HI_SUB  4
`define BFPDEN_QUD_LO_ADD  1
`define BFPDEN_QUD_HI_SUB  7
`endif

// [test/bfpden_props.sv]
`timescale 1ns/1ps
// ==================================================
// port-level checks of the denormalizer
module bfpden_props (
    // clock and reset
    input wire        clk,
    input wire        rstn,
    // stream in
    input wire [3:0]  log2Len,
    input wire        quadEngine,
    input wire        pairMode,
    input wire        inValid,
    input wire        inInverse,
    input wire [15:0] realIn,
    input wire [15:0] imagIn,
    input wire [5:0]  blockExp,
    // stream out
    input wire        outValid,
    input wire [36:0] fullReal,
    input wire [36:0] fullImag,
    input wire [15:0] sliceReal,
    input wire        expRangeErr,
    input wire [6:0]  totalExp,
    input wire [5:0]  inverseStageExp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    valid_lag_a: assert property (outValid == $past(inValid)) else $error("outValid lag");
    idle_hold_a: assert property (!inValid |=> $stable(fullReal) && $stable(sliceReal))
        else $error("output moved when idle");
    same_shift_a: assert property (inValid && realIn == imagIn |=> fullReal == fullImag)
        else $error("real and imag differ");
    sign_fill_a: assert property (inValid |=> fullReal[36] == $past(realIn[15])) else $error("sign lost");
    walk_place_a: assert property (inValid && !pairMode && quadEngine && log2Len == 4'h8 && blockExp == 6'h3B
        |=> fullReal == ({{21{$past(realIn[15])}}, $past(realIn)} << 5)) else $error("placement wrong");
    range_sat_a: assert property (outValid && expRangeErr |-> fullReal == {fullReal[36], {36{~fullReal[36]}}})
        else $error("range not saturated");
    slice_sat_a: assert property (outValid && !fullReal[36] && fullReal[35:15] != 0 |-> sliceReal == 16'h7FFF)
        else $error("slice wrapped");
    total_exp_a: assert property (inValid && !pairMode |=> totalExp == {$past(blockExp[5]), $past(blockExp)})
        else $error("totalExp wrong");
    keep_inv_a: assert property (inValid && pairMode && inInverse |=> inverseStageExp == $past(blockExp))
        else $error("inverse exponent not kept");
    cover property (outValid && expRangeErr);
    cover property (inValid && pairMode && !inInverse);
    cover property (outValid && sliceReal == 16'h7FFF);
endmodule // bfpden_props
bind bfpden_denormalizer bfpden_props bfpden_props_i (.clk(clk), .rstn(rstn), .log2Len(log2Len),
    .quadEngine(quadEngine), .pairMode(pairMode), .inValid(inValid), .inInverse(inInverse), .realIn(realIn),
    .imagIn(imagIn), .blockExp(blockExp), .outValid(outValid), .fullReal(fullReal), .fullImag(fullImag),
    .sliceReal(sliceReal), .expRangeErr(expRangeErr), .totalExp(totalExp), .inverseStageExp(inverseStageExp));

// [test/bfpden_src_model.sv]
`timescale 1ns/1ps
// ==================================================
// transform engine output side, one sample per call
module bfpden_src_model (
    // clock
    input  wire         clk,
    // sample stream
    output logic        inValid,
    output logic        inInverse,
    output logic [15:0] realIn,
    output logic [15:0] imagIn,
    output logic [5:0]  blockExp
);
    initial begin
        {inValid, inInverse, realIn, imagIn, blockExp} = '0;
    end
    // exponent is passed as given so range faults can be commanded
    task automatic send(input logic [15:0] re, input logic [15:0] im, input logic [5:0] e, input logic inv);
        @(posedge clk);
        #1;
        {inValid, inInverse, realIn, imagIn, blockExp} = {1'b1, inv, re, im, e};
        @(posedge clk);
        #1;
        // released lines must not keep the last sample
        {inValid, realIn, imagIn, blockExp} = {1'b0, ~re, ~im, ~e};
    endtask
endmodule // bfpden_src_model

// [test/test_bfp_output_denormalizer.sv]
`timescale 1ns/1ps
// ==================================================
// bench top
module test_bfp_output_denormalizer;
    logic        clk, rstn, quadEngine, pairMode, inValid, inInverse, outValid, sliceSat, expRangeErr, needDivByN;
    logic [3:0]  log2Len;
    logic [15:0] realIn, imagIn, sliceReal, sliceImag;
    logic [5:0]  blockExp, inverseStageExp;
    logic [36:0] fullReal, fullImag;
    bit          held;
    logic [6:0]  totalExp;
    int          bad_count, tests_run, invKeep, e;
    bfpden_src_model bfpden_src_model_i (.clk(clk), .inValid(inValid), .inInverse(inInverse), .realIn(realIn),
        .imagIn(imagIn), .blockExp(blockExp));
    bfpden_denormalizer bfpden_denormalizer_i (.clk(clk), .rstn(rstn), .log2Len(log2Len), .quadEngine(quadEngine),
        .pairMode(pairMode), .inValid(inValid), .inInverse(inInverse), .realIn(realIn), .imagIn(imagIn),
        .blockExp(blockExp), .outValid(outValid), .fullReal(fullReal), .fullImag(fullImag), .sliceReal(sliceReal),
        .sliceImag(sliceImag), .sliceSat(sliceSat), .expRangeErr(expRangeErr), .totalExp(totalExp),
        .inverseStageExp(inverseStageExp), .needDivByN(needDivByN));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [37:0] want, input logic [37:0] got);
        tests_run++;
        if (got !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, want, got);
        end
    endtask
    function automatic logic [36:0] fullOf(input logic [15:0] s, input int sh, input bit err);
        logic [36:0] x;
        x = {{21{s[15]}}, s};
        if (err) return s[15] ? {1'b1, 36'h0} : {1'b0, {36{1'b1}}};
        if (sh > 0) return $signed(x) >>> sh;
        return x << (-sh);
    endfunction
    function automatic bit fits(input logic [36:0] x);
        return (x[36:15] == '0) || (x[36:15] == '1);
    endfunction
    // positive exponents shift right with sign fill and no rounding
    task automatic run(input logic [15:0] re, input logic [15:0] im, input int ex, input int n, input bit q,
                       input bit inv);
        int p, lo, hi, ea;
        bit err;
        logic [36:0] fr, fi;
        p = (n + 1) / 2;
        lo = -3 * p + n % 2 + q;
        hi = p + n % 2 - (q ? 7 : 4);
        err = (ex < lo) || (ex > hi);
        ea = ex + ((pairMode && !inv) ? invKeep : 0);
        fr = fullOf(re, ea, err);
        fi = fullOf(im, ea, err);
        log2Len = n[3:0];
        quadEngine = q;
        bfpden_src_model_i.send(re, im, ex[5:0], inv);
        chk("fullReal", fr, fullReal);
        chk("fullImag", fi, fullImag);
        chk("sliceReal", fits(fr) ? fr[15:0] : (fr[36] ? 16'h8000 : 16'h7FFF), sliceReal);
        chk("sliceSat", err || !fits(fr) || !fits(fi), sliceSat);
        chk("expRangeErr", err, expRangeErr);
        chk("totalExp", ea[6:0], totalExp);
        chk("needDivByN", inv || (pairMode && held), needDivByN);
        if (pairMode && inv) begin
            invKeep = ex;
            held = 1;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rstn, quadEngine, pairMode, log2Len} = '0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1;
        chk("outValid", 0, outValid);
        void'($urandom(59886));
        run(16'h0280, 16'h0280, -5, 8, 1, 0);
        run(16'h8000, 16'h7FFF, -21, 14, 0, 0);
        run(16'hF100, 16'h0100, 3, 14, 0, 0);
        run(16'h7FFF, 16'h8001, -11, 8, 1, 0);
        run(16'h1234, 16'h8000, -1, 8, 1, 0);
        repeat (60) begin
            e = -23 + int'($urandom % 26);
            run($urandom, $urandom, e, 6 + int'($urandom % 9), $urandom % 2, $urandom % 2);
        end
        pairMode = 1;
        run(16'h0100, 16'hFF00, -3, 8, 1, 1);
        chk("inverseStageExp", 6'h3D, inverseStageExp);
        run(16'h0040, 16'h0010, -4, 8, 1, 0);
        summarize();
    end
    initial begin
        #100us;
        bad_count++;
        summarize();
    end
endmodule // test_bfp_output_denormalizer
